// ===== src/meter_uart_slave_port.sv
`timescale 1ns/10ps
`default_nettype none
`include "meter_uart_regs.svh"
// Function
// - device only answers master frames, never starts a transfer
// - half-duplex: receive and transmit overlap only when a start bit and a reply are taken in the same cycle
// - 11-bit character: start low, 8 data, parity, stop high
// - odd parity over data plus parity bit, sent and checked
// - data bits shifted lsb first both ways
// - bit timing from divided kernel clock, 4800 bps
// - kernel clock from crystal clock, fallback clock when crystal stops
// - power-on, receive-line or software reset clears the port
// - sleep mode keeps the port idle
// - gap over 16 bit times drops the frame
// - reply gated by port state only, broadcast frames included
// - write frame answered with four characters
module meter_uart_slave_port
  import meter_uart_pkg::*;
#(
  parameter int BIT_CYCLES = `BIT_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CRYSTAL_OK,
  input wire logic I_RX_LINE_RST,
  input wire logic I_SW_RST,
  input wire logic I_SLEEP,
  input wire logic I_RX,
  output logic O_TX,
  output logic O_CMD_VALID,
  output cmd_s O_CMD,
  input wire logic I_CMD_READY,
  input wire logic I_RSP_VALID,
  input wire logic [31:0] I_RSP,
  output logic O_RSP_READY,
  output logic O_RX_ERR
);
  localparam int HALF = BIT_CYCLES / 2;
  // kernel clock source select; fallback is coarse, only the choice is tracked
  logic on_crystal;
  assign on_crystal = I_CRYSTAL_OK;
  // synchronous reset sources fold into one clear
  logic clr;
  assign clr = I_RX_LINE_RST | I_SW_RST;

  rx_state_e rx_st_ff, nxt_rx_st;
  logic [15:0] rx_cnt_ff, nxt_rx_cnt;
  logic [3:0] rx_bit_ff, nxt_rx_bit;
  logic [10:0] rx_sh_ff, nxt_rx_sh;
  logic [2:0] rx_chr_ff, nxt_rx_chr;
  logic [20:0] gap_ff, nxt_gap;
  logic [63:0] frm_ff, nxt_frm;
  logic in_frame_ff, nxt_in_frame;
  logic err_ff, nxt_err;
  // two-entry buffer between receiver and consumer
  cmd_s buf_ff [2];
  cmd_s nxt_buf [2];
  logic [1:0] cnt_ff, nxt_cnt;
  logic push;
  cmd_s push_cmd;
  logic pop;

  tx_state_e tx_st_ff, nxt_tx_st;
  logic [15:0] tx_cnt_ff, nxt_tx_cnt;
  logic [3:0] tx_bit_ff, nxt_tx_bit;
  logic [10:0] tx_sh_ff, nxt_tx_sh;
  logic [2:0] tx_chr_ff, nxt_tx_chr;
  logic [31:0] tx_word_ff, nxt_tx_word;
  logic tx_ff, nxt_tx;
  logic busy_tx;

  assign busy_tx = (tx_st_ff != TX_IDLE);
  assign pop = O_CMD_VALID & I_CMD_READY;
  assign O_CMD_VALID = (cnt_ff != 2'd0);
  assign O_CMD = buf_ff[0];
  assign O_RX_ERR = err_ff;
  assign O_TX = tx_ff;
  // reply taken only with rx and tx idle and no frame in progress; frame kind not checked
  assign O_RSP_READY = (tx_st_ff == TX_IDLE) & ~I_SLEEP & ~clr & on_crystal
    & (rx_st_ff == RX_IDLE) & ~in_frame_ff;

  always_comb begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_cnt = rx_cnt_ff;
    nxt_rx_bit = rx_bit_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_chr = rx_chr_ff;
    nxt_gap = gap_ff;
    nxt_frm = frm_ff;
    nxt_in_frame = in_frame_ff;
    nxt_err = 1'b0;
    push = 1'b0;
    push_cmd = '0;
    if (in_frame_ff && rx_st_ff == RX_IDLE) begin
      if (gap_ff >= 21'(`GAP_BITS * BIT_CYCLES)) begin
        nxt_in_frame = 1'b0;
        nxt_rx_chr = 3'd0;
        nxt_gap = 21'd0;
      end else begin
        nxt_gap = gap_ff + 21'd1;
      end
    end
    unique case (rx_st_ff)
      RX_IDLE: begin
        // receiver ignores the line while transmitting
        if (!I_RX && !busy_tx) begin
          nxt_rx_st = RX_SHIFT;
          nxt_rx_cnt = 16'(HALF);
          nxt_rx_bit = 4'd0;
          nxt_gap = 21'd0;
        end
      end
      RX_SHIFT: begin
        if (rx_cnt_ff != 16'd0) begin
          nxt_rx_cnt = rx_cnt_ff - 16'd1;
        end else begin
          // mid-bit sample; lsb first into the top
          nxt_rx_sh = {I_RX, rx_sh_ff[10:1]};
          nxt_rx_cnt = 16'(BIT_CYCLES - 1);
          nxt_rx_bit = rx_bit_ff + 4'd1;
          if (rx_bit_ff == 4'd0 && I_RX) begin
            nxt_rx_st = RX_IDLE;
          end else if (rx_bit_ff == 4'(`CHAR_BITS - 1)) begin
            nxt_rx_st = RX_IDLE;
            nxt_gap = 21'd0;
            // stop high; odd parity over nine bits
            if (!I_RX || !(^rx_sh_ff[10:2])) begin
              nxt_err = 1'b1;
              nxt_rx_st = RX_DROP;
              nxt_in_frame = 1'b0;
              nxt_rx_chr = 3'd0;
            end else begin
              nxt_frm = {rx_sh_ff[9:2], frm_ff[63:8]};
              nxt_in_frame = 1'b1;
              nxt_rx_chr = rx_chr_ff + 3'd1;
              if (rx_chr_ff == 3'(`CMD_CHARS - 1)) begin
                nxt_in_frame = 1'b0;
                nxt_rx_chr = 3'd0;
                push = (frm_ff[15:8] == `HEAD_BYTE);
                push_cmd.addr_hi = frm_ff[23:20];
                push_cmd.kind = frm_ff[`CTRL_TYPE_LSB + 16 +: `CTRL_TYPE_W];
                push_cmd.addr_lo = frm_ff[31:24];
                // checksum char is the one just sampled and is not kept
                push_cmd.data = frm_ff[63:32];
              end
            end
          end
        end
      end
      RX_DROP: begin
        // rest of frame ignored until the line stays idle a gap
        if (!I_RX) begin
          nxt_gap = 21'd0;
        end else if (gap_ff >= 21'(`GAP_BITS * BIT_CYCLES)) begin
          nxt_rx_st = RX_IDLE;
          nxt_gap = 21'd0;
        end else begin
          nxt_gap = gap_ff + 21'd1;
        end
      end
      default: nxt_rx_st = RX_IDLE;
    endcase
    // sleep holds the port idle; resets discard partials
    if (I_SLEEP || clr || !on_crystal) begin
      nxt_rx_st = RX_IDLE;
      nxt_in_frame = 1'b0;
      nxt_rx_chr = 3'd0;
      nxt_gap = 21'd0;
      push = 1'b0;
    end
  end

  // buffer full drops the frame rather than stalling the wire
  always_comb begin
    nxt_buf = buf_ff;
    nxt_cnt = cnt_ff;
    if (pop) begin
      nxt_buf[0] = buf_ff[1];
      nxt_cnt = cnt_ff - 2'd1;
    end
    if (push && nxt_cnt != 2'd2) begin
      nxt_buf[nxt_cnt[0]] = push_cmd;
      nxt_cnt = nxt_cnt + 2'd1;
    end
    if (clr) begin
      nxt_cnt = 2'd0;
    end
  end

  always_comb begin
    nxt_tx_st = tx_st_ff;
    nxt_tx_cnt = tx_cnt_ff;
    nxt_tx_bit = tx_bit_ff;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_chr = tx_chr_ff;
    nxt_tx_word = tx_word_ff;
    nxt_tx = tx_ff;
    unique case (tx_st_ff)
      TX_IDLE: begin
        nxt_tx = 1'b1;
        if (I_RSP_VALID && O_RSP_READY) begin
          nxt_tx_st = TX_SEND;
          nxt_tx_word = I_RSP;
          nxt_tx_chr = 3'd0;
          nxt_tx_bit = 4'd0;
          nxt_tx_cnt = 16'd0;
          nxt_tx_sh = {1'b1, ~(^I_RSP[7:0]), I_RSP[7:0], 1'b0};
        end
      end
      TX_SEND: begin
        if (tx_cnt_ff != 16'd0) begin
          nxt_tx_cnt = tx_cnt_ff - 16'd1;
        end else begin
          // lsb first; one bit per divided period
          nxt_tx = tx_sh_ff[0];
          nxt_tx_sh = {1'b1, tx_sh_ff[10:1]};
          nxt_tx_cnt = 16'(BIT_CYCLES - 1);
          nxt_tx_bit = tx_bit_ff + 4'd1;
          if (tx_bit_ff == 4'(`CHAR_BITS)) begin
            nxt_tx = 1'b1;
            nxt_tx_bit = 4'd0;
            nxt_tx_cnt = 16'd0;
            nxt_tx_chr = tx_chr_ff + 3'd1;
            nxt_tx_word = {8'h00, tx_word_ff[31:8]};
            nxt_tx_sh = {1'b1, ~(^tx_word_ff[15:8]), tx_word_ff[15:8], 1'b0};
            if (tx_chr_ff == 3'(`RSP_CHARS - 1)) begin
              nxt_tx_st = TX_IDLE;
            end
          end
        end
      end
      default: nxt_tx_st = TX_IDLE;
    endcase
    if (I_SLEEP || clr) begin
      nxt_tx_st = TX_IDLE;
      nxt_tx = 1'b1;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rx_st_ff <= RX_IDLE;
      rx_cnt_ff <= 16'h0000;
      rx_bit_ff <= 4'h0;
      rx_sh_ff <= 11'h7ff;
      rx_chr_ff <= 3'h0;
      gap_ff <= 21'h000000;
      frm_ff <= 64'h0;
      in_frame_ff <= 1'b0;
      err_ff <= 1'b0;
      buf_ff[0] <= '0;
      buf_ff[1] <= '0;
      cnt_ff <= 2'h0;
      tx_st_ff <= TX_IDLE;
      tx_cnt_ff <= 16'h0000;
      tx_bit_ff <= 4'h0;
      tx_sh_ff <= 11'h7ff;
      tx_chr_ff <= 3'h0;
      tx_word_ff <= 32'h0;
      tx_ff <= 1'b1;
    end else begin
      rx_st_ff <= nxt_rx_st;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_bit_ff <= nxt_rx_bit;
      rx_sh_ff <= nxt_rx_sh;
      rx_chr_ff <= nxt_rx_chr;
      gap_ff <= nxt_gap;
      frm_ff <= nxt_frm;
      in_frame_ff <= nxt_in_frame;
      err_ff <= nxt_err;
      buf_ff <= nxt_buf;
      cnt_ff <= nxt_cnt;
      tx_st_ff <= nxt_tx_st;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_bit_ff <= nxt_tx_bit;
      tx_sh_ff <= nxt_tx_sh;
      tx_chr_ff <= nxt_tx_chr;
      tx_word_ff <= nxt_tx_word;
      tx_ff <= nxt_tx;
    end
  end
endmodule
`default_nettype wire

// ===== src/meter_uart_regs.svh
`ifndef METER_UART_REGS_SVH
`define METER_UART_REGS_SVH
`define CLK_HZ 100000000
`define BAUD_BPS 4800
`define BIT_CYCLES (`CLK_HZ / `BAUD_BPS)
`define HALF_BIT_CYCLES (`BIT_CYCLES / 2)
`define CHAR_BITS 11
`define GAP_BITS 16
`define CMD_CHARS 8
`define RSP_CHARS 4
`define HEAD_BYTE 8'hfe
`define CTRL_TYPE_LSB 0
`define CTRL_TYPE_W 4
`define CTRL_WRITE 4'h2
`define CTRL_BCAST 4'h3
`endif

// ===== src/meter_uart_pkg.sv
`default_nettype none
package meter_uart_pkg;
  typedef struct packed {
    logic [3:0] addr_hi;
    logic [7:0] addr_lo;
    logic [31:0] data;
    logic [3:0] kind;
  } cmd_s;
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_SHIFT,
    RX_DROP
  } rx_state_e;
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SEND
  } tx_state_e;
endpackage
`default_nettype wire

// ===== test/meter_uart_slave_port_properties.sv
`timescale 1ns/10ps
`default_nettype none
module meter_uart_slave_port_properties
  import meter_uart_pkg::*;
#(
  parameter int BIT_CYCLES = 16
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CRYSTAL_OK,
  input wire logic I_RX_LINE_RST,
  input wire logic I_SW_RST,
  input wire logic I_SLEEP,
  input wire logic O_TX,
  input wire logic O_CMD_VALID,
  input wire cmd_s O_CMD,
  input wire logic I_CMD_READY,
  input wire logic O_RSP_READY,
  input wire logic O_RX_ERR
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  a_sleep_tx_idle: assert property ($past(I_SLEEP) |-> O_TX)
    else $error("tx active in sleep");
  a_sleep_no_reply: assert property (I_SLEEP |-> !O_RSP_READY)
    else $error("reply accepted in sleep");
  a_fallback_no_reply: assert property (!I_CRYSTAL_OK |-> !O_RSP_READY)
    else $error("reply accepted on fallback clock");
  a_duplex_no_reply: assert property (!O_TX |-> !O_RSP_READY)
    else $error("reply accepted while sending");
  // start bit lasts a whole bit time, 16 cycles here; the check requires only the first 8
  a_start_bit_low: assert property ($fell(O_TX) |-> !O_TX [*8])
    else $error("start bit too short");
  a_err_one_cycle: assert property (O_RX_ERR |=> !O_RX_ERR)
    else $error("error flag longer than a cycle");
  a_clear_empties: assert property ((I_SW_RST || I_RX_LINE_RST) |=> !O_CMD_VALID)
    else $error("buffer kept after clear");
  a_cmd_held: assert property (O_CMD_VALID && !I_CMD_READY && !I_SW_RST && !I_RX_LINE_RST
    |=> O_CMD_VALID && $stable(O_CMD))
    else $error("command changed while stalled");
endmodule
bind meter_uart_slave_port meter_uart_slave_port_properties #(.BIT_CYCLES(BIT_CYCLES)) u_props (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_CRYSTAL_OK(I_CRYSTAL_OK), .I_RX_LINE_RST(I_RX_LINE_RST),
  .I_SW_RST(I_SW_RST), .I_SLEEP(I_SLEEP), .O_TX(O_TX), .O_CMD_VALID(O_CMD_VALID),
  .O_CMD(O_CMD), .I_CMD_READY(I_CMD_READY), .O_RSP_READY(O_RSP_READY), .O_RX_ERR(O_RX_ERR));
`default_nettype wire

// ===== test/meter_uart_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module meter_uart_master_model #(
  parameter int BC = 16
) (
  input wire logic i_clk,
  input wire logic i_tx,
  output logic o_rx
);
  logic [9:0] got_q[$];
  logic [10:0] f;
  initial o_rx = 1'b1;
  task automatic send_char(input logic [7:0] b, input logic bad);
    logic [10:0] s;
    s = {1'b1, ~^b ^ bad, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      o_rx = s[i];
      repeat (BC) @(posedge i_clk);
      #1;
    end
  endtask
  always begin
    @(negedge i_tx);
    repeat (BC / 2) @(posedge i_clk);
    for (int i = 0; i < 11; i++) begin
      f[i] = i_tx;
      if (i < 10) repeat (BC) @(posedge i_clk);
    end
    got_q.push_back(f[10:1]);
  end
endmodule
`default_nettype wire

// ===== test/meter_uart_slave_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
module meter_uart_slave_port_tb;
  import meter_uart_pkg::*;
  localparam int BC = 16;
  localparam int GAP = 18 * BC;
  logic clk = 0, rst = 1, xtal = 1, lrst = 0, srst = 0, slp = 0, rdy = 0, rv = 0;
  logic [31:0] rsp = '0;
  logic tx, cv, rr, err, rx;
  cmd_s cmd;
  cmd_s exp_q[$];
  int num_errors = 0, samples_checked = 0, cyc = 0, errs = 0;
  meter_uart_slave_port #(.BIT_CYCLES(BC)) u_meter_uart_slave_port (.I_CLK(clk),
    .I_RST(rst), .I_CRYSTAL_OK(xtal), .I_RX_LINE_RST(lrst), .I_SW_RST(srst), .I_SLEEP(slp),
    .I_RX(rx), .O_TX(tx), .O_CMD_VALID(cv), .O_CMD(cmd), .I_CMD_READY(rdy),
    .I_RSP_VALID(rv), .I_RSP(rsp), .O_RSP_READY(rr), .O_RX_ERR(err));
  meter_uart_master_model #(.BC(BC)) u_meter_uart_master_model (.i_clk(clk), .i_tx(tx),
    .o_rx(rx));
  initial forever #5 clk = ~clk;
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
    samples_checked++;
    if (e !== s) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // model frame; only pushed frames must come out
  task automatic frame(input logic [3:0] k, input int n, input logic push);
    cmd_s c;
    logic [7:0] b[8];
    c = {4'($urandom), 8'($urandom), $urandom, k};
    b = '{8'hfe, {c.addr_hi, k}, c.addr_lo, c.data[7:0], c.data[15:8], c.data[23:16],
      c.data[31:24], 8'h00};
    if (push) exp_q.push_back(c);
    for (int i = 0; i < n; i++) u_meter_uart_master_model.send_char(b[i], 1'b0);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (err === 1'b1) errs++;
    if (cv === 1'b1 && rdy === 1'b1) chk("cmd", exp_q.size() ? exp_q.pop_front() : 'x, cmd);
    if (cyc == 40000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    logic [31:0] w;
    void'($urandom(22));
    repeat (5) @(posedge clk);
    #1 rst = 0;
    chk("tx idle", 1, tx);
    chk("cmd valid", 0, cv);
    frame(2, 8, 1);
    frame(3, 8, 1);
    frame(2, 8, 0);
    chk("buffer full", 1, cv);
    rdy = 1;
    repeat (4) @(posedge clk);
    #1 chk("no reply", 0, u_meter_uart_master_model.got_q.size());
    w = $urandom;
    chk("rsp ready", 1, rr);
    rsp = w;
    rv = 1;
    @(posedge clk);
    #1 rv = 0;
    repeat (44 * BC + 20) @(posedge clk);
    for (int i = 0; i < 4; i++) chk("tx char", {1'b1, ~^w[8*i+:8], w[8*i+:8]},
      u_meter_uart_master_model.got_q.pop_front());
    chk("tx extra", 0, u_meter_uart_master_model.got_q.size());
    u_meter_uart_master_model.send_char(8'hfe, 1'b0);
    u_meter_uart_master_model.send_char(8'h52, 1'b1);
    repeat (GAP) @(posedge clk);
    #1 chk("rx err", 1, errs);
    frame(2, 3, 0);
    repeat (GAP) @(posedge clk);
    #1 frame(3, 8, 1);
    for (int r = 0; r < 2; r++) begin
      frame(2, 4, 0);
      if (r == 0) lrst = 1;
      else srst = 1;
      @(posedge clk);
      #1 lrst = 0;
      srst = 0;
      frame(2, 8, 1);
    end
    slp = 1;
    // ready is combinational, so look mid-cycle once it has settled
    #4 chk("sleep ready", 0, rr);
    @(posedge clk);
    #1 frame(2, 8, 0);
    slp = 0;
    xtal = 0;
    #4 chk("fallback ready", 0, rr);
    @(posedge clk);
    #1 frame(3, 8, 0);
    xtal = 1;
    repeat (GAP) @(posedge clk);
    #1 chk("left over", 0, exp_q.size());
    chk("rx err total", 1, errs);
    conclude();
  end
endmodule
`default_nettype wire
